// File: rtl/ram_page_pkg.sv
// Purpose: Constants for the data RAM page mapper.
// Assumes: 13-bit nibble addresses into an 8K x 4 data RAM.
// Notes: Offsets, reset values and field positions live here.
package ram_page_pkg;
    // ==================================================
    // Address map
    localparam logic [12:0] FIRST_BACKUP_BASE = 13'h0080;
    localparam logic [12:0] SECOND_BACKUP_BASE = 13'h00c0;
    localparam logic [12:0] STACK_BASE = 13'h0200;
    localparam logic [12:0] DISPLAY_BASE = 13'h0100;
    localparam logic [12:0] DISPLAY_HIGH_BASE = 13'h0101;
    // ==================================================
    // Page settings
    localparam logic [1:0] DISPLAY_INIT_PAGE = 2'h0;
    localparam logic [8:0] WORK_INIT_PAGE = 9'h007;
    localparam logic [5:0] DATA_INIT_PAGE = 6'h00;
    localparam int DATA_RELEASE_POS = 0;
    localparam int WORK_RELEASE_POS = 1;
    localparam int DISPLAY_RELEASE_POS = 2;
    // ==================================================
    // Access kinds and page commands
    typedef enum logic [3:0] {
        ACC_NONE,
        ACC_DATA_DIRECT,
        ACC_WORK_DIRECT,
        ACC_DISPLAY_DIRECT,
        ACC_INDEX,
        ACC_FIRST_BACKUP,
        ACC_SECOND_BACKUP,
        ACC_STACK
    } access_kind_t;
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_ONESHOT_DATA,
        CMD_LOCK_DATA,
        CMD_ONESHOT_WORK,
        CMD_LOCK_WORK,
        CMD_ONESHOT_DISPLAY,
        CMD_LOCK_DISPLAY,
        CMD_CLEAR_LOCKS
    } page_cmd_t;
endpackage

// File: rtl/data_ram_page_mapper.sv
// Purpose: Forms data RAM nibble addresses for every addressing mode and
//          keeps the page settings and the interrupt hold-off.
// Assumes: The core presents one access or page command per instruction,
//          accesses qualified by accessValid, commands by instrDone at the last cycle of the instruction.
// Notes: All outputs are registered, one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module data_ram_page_mapper
    import ram_page_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instrDone,
    input wire logic accessValid,
    input wire access_kind_t accessKind,
    input wire logic accessWrite,
    input wire logic byteWide,
    input wire logic [6:0] directOffset,
    input wire logic [3:0] operandX,
    input wire logic [1:0] nibbleSel,
    input wire logic [12:0] indexAddress,
    input wire logic [7:0] writeByte,
    input wire logic [3:0] writeNibble,
    input wire page_cmd_t pageCmd,
    input wire logic [8:0] pageValue,
    input wire logic compareMatch,
    output logic [12:0] ramAddress,
    output logic ramWrite,
    output logic ramWriteHigh,
    output logic [3:0] ramDataLow,
    output logic [3:0] ramDataHigh,
    output logic accessRefused,
    output logic squashNext,
    output logic irqInhibit,
    output logic [1:0] displayPage,
    output logic [8:0] workPage
);
    // ==================================================
    // Page state
    logic displayLock_reg, displayLock_next;
    logic workLock_reg, workLock_next;
    logic dataLock_reg, dataLock_next;
    logic [1:0] dispLockPage_reg, dispLockPage_next;
    logic [8:0] workLockPage_reg, workLockPage_next;
    logic [5:0] dataLockPage_reg, dataLockPage_next;
    logic [1:0] dispShot_reg, dispShot_next;
    logic [8:0] workShot_reg, workShot_next;
    logic [5:0] dataShot_reg, dataShot_next;
    logic shotArmed_reg, shotArmed_next;
    logic [1:0] dispBase, dispPageAhead;
    logic [8:0] workBase, workPageAhead;
    logic [5:0] dataBase, dataPageNow;
    logic [1:0] holdCount_reg, holdCount_next;
    logic squash_reg, squash_next;
    logic [1:0] dispPageNow;
    logic [8:0] workPageNow;
    logic cmdLive;

    always_comb begin
        // A squashed instruction executes as a no-op.
        cmdLive = instrDone && !squash_reg;
        dispBase = displayLock_reg ? dispLockPage_reg : DISPLAY_INIT_PAGE;
        workBase = workLock_reg ? workLockPage_reg : WORK_INIT_PAGE;
        dataBase = dataLock_reg ? dataLockPage_reg : DATA_INIT_PAGE;
        displayLock_next = displayLock_reg;
        workLock_next = workLock_reg;
        dataLock_next = dataLock_reg;
        dispLockPage_next = dispLockPage_reg;
        workLockPage_next = workLockPage_reg;
        dataLockPage_next = dataLockPage_reg;
        dispShot_next = dispShot_reg;
        workShot_next = workShot_reg;
        dataShot_next = dataShot_reg;
        shotArmed_next = shotArmed_reg;
        holdCount_next = holdCount_reg;
        squash_next = squash_reg;
        if (instrDone) begin
            squash_next = cmdLive && compareMatch;
            if (holdCount_reg != 2'h0) begin
                holdCount_next = holdCount_reg - 2'h1;
            end
            // A one-shot page ends with the instruction that uses it.
            shotArmed_next = 1'b0;
        end
        if (cmdLive) begin
            case (pageCmd)
                CMD_ONESHOT_DATA: begin
                    dataShot_next = pageValue[5:0];
                    dispShot_next = dispBase;
                    workShot_next = workBase;
                    shotArmed_next = 1'b1;
                    holdCount_next = 2'h2;
                end
                CMD_ONESHOT_WORK: begin
                    workShot_next = pageValue;
                    dispShot_next = dispBase;
                    dataShot_next = dataBase;
                    shotArmed_next = 1'b1;
                    holdCount_next = 2'h2;
                end
                CMD_ONESHOT_DISPLAY: begin
                    dispShot_next = pageValue[1:0];
                    workShot_next = workBase;
                    dataShot_next = dataBase;
                    shotArmed_next = 1'b1;
                    holdCount_next = 2'h2;
                end
                CMD_LOCK_DATA: begin
                    dataLock_next = 1'b1;
                    dataLockPage_next = pageValue[5:0];
                end
                CMD_LOCK_WORK: begin
                    workLock_next = 1'b1;
                    workLockPage_next = pageValue;
                end
                CMD_LOCK_DISPLAY: begin
                    displayLock_next = 1'b1;
                    dispLockPage_next = pageValue[1:0];
                end
                CMD_CLEAR_LOCKS: begin
                    if (pageValue[DATA_RELEASE_POS]) begin
                        dataLock_next = 1'b0;
                        dataLockPage_next = DATA_INIT_PAGE;
                    end
                    if (pageValue[WORK_RELEASE_POS]) begin
                        workLock_next = 1'b0;
                        workLockPage_next = WORK_INIT_PAGE;
                    end
                    if (pageValue[DISPLAY_RELEASE_POS]) begin
                        displayLock_next = 1'b0;
                        dispLockPage_next = DISPLAY_INIT_PAGE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            displayLock_reg <= 1'b0;
            workLock_reg <= 1'b0;
            dataLock_reg <= 1'b0;
            dispLockPage_reg <= DISPLAY_INIT_PAGE;
            workLockPage_reg <= WORK_INIT_PAGE;
            dataLockPage_reg <= DATA_INIT_PAGE;
            dispShot_reg <= DISPLAY_INIT_PAGE;
            workShot_reg <= WORK_INIT_PAGE;
            dataShot_reg <= DATA_INIT_PAGE;
            shotArmed_reg <= 1'b0;
            holdCount_reg <= 2'h0;
            squash_reg <= 1'b0;
        end else begin
            displayLock_reg <= displayLock_next;
            workLock_reg <= workLock_next;
            dataLock_reg <= dataLock_next;
            dispLockPage_reg <= dispLockPage_next;
            workLockPage_reg <= workLockPage_next;
            dataLockPage_reg <= dataLockPage_next;
            dispShot_reg <= dispShot_next;
            workShot_reg <= workShot_next;
            dataShot_reg <= dataShot_next;
            shotArmed_reg <= shotArmed_next;
            holdCount_reg <= holdCount_next;
            squash_reg <= squash_next;
        end
    end

    // ==================================================
    // Effective pages
    always_comb begin
        // A one-shot page applies to the next instruction only.
        if (shotArmed_reg) begin
            dispPageNow = dispShot_reg;
            workPageNow = workShot_reg;
            dataPageNow = dataShot_reg;
        end else begin
            dispPageNow = dispBase;
            workPageNow = workBase;
            dataPageNow = dataBase;
        end
        // The page outputs show the pages of the next instruction.
        if (shotArmed_next) begin
            dispPageAhead = dispShot_next;
            workPageAhead = workShot_next;
        end else begin
            dispPageAhead = displayLock_next ? dispLockPage_next
                                             : DISPLAY_INIT_PAGE;
            workPageAhead = workLock_next ? workLockPage_next
                                          : WORK_INIT_PAGE;
        end
    end

    // ==================================================
    // Address formation
    logic [12:0] addrNext;
    logic writeNext, writeHighNext, refusedNext;
    logic [3:0] dataLowNext, dataHighNext;
    logic [6:0] dispByteAddr;

    always_comb begin
        dispByteAddr = {dispPageNow, directOffset[4:0]};
        addrNext = ramAddress;
        writeNext = 1'b0;
        writeHighNext = 1'b0;
        refusedNext = 1'b0;
        dataLowNext = writeNibble;
        dataHighNext = 4'h0;
        if (accessValid && !squash_reg) begin
            case (accessKind)
                ACC_DATA_DIRECT: begin
                    addrNext = {dataPageNow, directOffset};
                    writeNext = accessWrite;
                end
                ACC_WORK_DIRECT: begin
                    addrNext = {workPageNow, directOffset[3:0]};
                    writeNext = accessWrite;
                end
                ACC_DISPLAY_DIRECT: begin
                    // Only display nibbles 0x100..0x1ff are reachable.
                    addrNext = DISPLAY_BASE
                             + {5'h00, dispByteAddr, 1'b0};
                    writeNext = accessWrite;
                    refusedNext = !accessWrite;
                    writeHighNext = accessWrite && byteWide;
                    dataLowNext = byteWide ? writeByte[3:0] : writeNibble;
                    dataHighNext = writeByte[7:4];
                end
                ACC_INDEX: begin
                    addrNext = indexAddress;
                    writeNext = accessWrite;
                    writeHighNext = accessWrite && byteWide;
                    dataLowNext = byteWide ? writeByte[3:0] : writeNibble;
                    dataHighNext = writeByte[7:4];
                end
                ACC_FIRST_BACKUP: begin
                    addrNext = FIRST_BACKUP_BASE
                             + {7'h00, operandX, nibbleSel};
                    writeNext = accessWrite;
                end
                ACC_SECOND_BACKUP: begin
                    addrNext = SECOND_BACKUP_BASE
                             + {7'h00, operandX, nibbleSel};
                    writeNext = accessWrite;
                    dataLowNext = (nibbleSel == 2'h3)
                                ? {3'h0, writeNibble[0]} : writeNibble;
                end
                ACC_STACK: begin
                    addrNext = STACK_BASE
                             + {7'h00, operandX, nibbleSel};
                    writeNext = accessWrite;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramAddress <= 13'h0000;
            ramWrite <= 1'b0;
            ramWriteHigh <= 1'b0;
            ramDataLow <= 4'h0;
            ramDataHigh <= 4'h0;
            accessRefused <= 1'b0;
            squashNext <= 1'b0;
            irqInhibit <= 1'b0;
            displayPage <= DISPLAY_INIT_PAGE;
            workPage <= WORK_INIT_PAGE;
        end else begin
            ramAddress <= addrNext;
            ramWrite <= writeNext;
            ramWriteHigh <= writeHighNext;
            ramDataLow <= dataLowNext;
            ramDataHigh <= dataHighNext;
            accessRefused <= refusedNext;
            squashNext <= squash_next;
            irqInhibit <= displayLock_next || workLock_next
                       || dataLock_next
                       || (holdCount_next != 2'h0);
            displayPage <= dispPageAhead;
            workPage <= workPageAhead;
        end
    end
endmodule
`default_nettype wire

// File: dv/ram_page_monitor.sv
// Purpose: Port checker for the data RAM page mapper.
// Assumes: Outputs are registered one cycle after the request.
// Notes: Attached by bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module ram_page_monitor
    import ram_page_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instrDone,
    input wire logic accessValid,
    input wire access_kind_t accessKind,
    input wire logic accessWrite,
    input wire logic byteWide,
    input wire logic [6:0] directOffset,
    input wire logic [3:0] operandX,
    input wire logic [1:0] nibbleSel,
    input wire logic [7:0] writeByte,
    input wire page_cmd_t pageCmd,
    input wire logic [8:0] pageValue,
    input wire logic compareMatch,
    input wire logic [12:0] ramAddress,
    input wire logic ramWrite,
    input wire logic ramWriteHigh,
    input wire logic [3:0] ramDataHigh,
    input wire logic accessRefused,
    input wire logic squashNext,
    input wire logic irqInhibit,
    input wire logic [1:0] displayPage,
    input wire logic [8:0] workPage
);
    // ==================================================
    // Qualified requests
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic cmd;
    logic disp;
    assign acc = accessValid && !squashNext;
    assign cmd = instrDone && !squashNext;
    assign disp = acc && accessKind == ACC_DISPLAY_DIRECT;
    // ==================================================
    // Assertions
    stack_addr_a: assert property (
        acc && accessKind == ACC_STACK |=> ramAddress == STACK_BASE
        + {$past(operandX), $past(nibbleSel)}) else $error("stack address");
    first_backup_a: assert property (
        acc && accessKind == ACC_FIRST_BACKUP |=> ramAddress == 13'h0080
        + {$past(operandX), $past(nibbleSel)}) else $error("backup address");
    display_write_a: assert property (
        disp && accessWrite |=> ramWrite && ramAddress == DISPLAY_BASE
        + {$past(displayPage), $past(directOffset[4:0]), 1'b0})
        else $error("display address");
    display_read_a: assert property (
        disp && !accessWrite |=> accessRefused && !ramWrite)
        else $error("display read");
    byte_high_a: assert property (
        disp && accessWrite && byteWide |=> ramWriteHigh
        && ramDataHigh == $past(writeByte[7:4])) else $error("byte write");
    work_addr_a: assert property (
        acc && accessKind == ACC_WORK_DIRECT |=>
        ramAddress == {$past(workPage), $past(directOffset[3:0])})
        else $error("work address");
    lock_inhibit_a: assert property (
        cmd && pageCmd inside {CMD_LOCK_DATA, CMD_LOCK_WORK,
        CMD_LOCK_DISPLAY, CMD_ONESHOT_WORK, CMD_ONESHOT_DISPLAY}
        |=> irqInhibit) else $error("interrupt hold-off");
    clear_display_a: assert property (
        cmd && pageCmd == CMD_CLEAR_LOCKS && pageValue[2]
        |=> displayPage == DISPLAY_INIT_PAGE) else $error("display clear");
    squash_next_a: assert property (
        cmd && compareMatch |=> squashNext) else $error("squash");
    cover property (disp && accessWrite && byteWide);
    cover property (cmd && pageCmd == CMD_LOCK_DISPLAY);
    cover property (cmd && compareMatch);
endmodule
`default_nettype wire

// File: dv/data_ram_page_mapper_bench.sv
// Purpose: Directed bench for the data RAM page mapper.
// Assumes: One request per task call, checked after the answer edge.
// Notes: Expected addresses are worked out from the address map.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module data_ram_page_mapper_bench;
    import ram_page_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instrDone = 1'b0, accessValid = 1'b0, accessWrite = 1'b0;
    logic byteWide = 1'b0, compareMatch = 1'b0;
    access_kind_t accessKind = ACC_NONE;
    page_cmd_t pageCmd = CMD_NONE;
    logic [6:0] directOffset = 7'h00;
    logic [3:0] operandX = 4'h0, writeNibble = 4'h0;
    logic [1:0] nibbleSel = 2'h0;
    logic [12:0] indexAddress = 13'h0000;
    logic [7:0] writeByte = 8'h5a;
    logic [8:0] pageValue = 9'h000;
    logic [12:0] ramAddress;
    logic ramWrite, ramWriteHigh, accessRefused, squashNext, irqInhibit;
    logic [3:0] ramDataLow, ramDataHigh;
    logic [1:0] displayPage;
    logic [8:0] workPage;
    int err_count = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    data_ram_page_mapper uut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .instrDone(instrDone),
        .accessValid(accessValid),
        .accessKind(accessKind),
        .accessWrite(accessWrite),
        .byteWide(byteWide),
        .directOffset(directOffset),
        .operandX(operandX),
        .nibbleSel(nibbleSel),
        .indexAddress(indexAddress),
        .writeByte(writeByte),
        .writeNibble(writeNibble),
        .pageCmd(pageCmd),
        .pageValue(pageValue),
        .compareMatch(compareMatch),
        .ramAddress(ramAddress),
        .ramWrite(ramWrite),
        .ramWriteHigh(ramWriteHigh),
        .ramDataLow(ramDataLow),
        .ramDataHigh(ramDataHigh),
        .accessRefused(accessRefused),
        .squashNext(squashNext),
        .irqInhibit(irqInhibit),
        .displayPage(displayPage),
        .workPage(workPage)
    );
    // ==================================================
    // Drivers
    task automatic acc(input access_kind_t k, input logic w,
        input logic [6:0] o, input logic [3:0] x = 4'h0,
        input logic [1:0] s = 2'h0);
        @(posedge sys_clk);
        accessValid <= 1'b1;
        accessKind <= k;
        accessWrite <= w;
        byteWide <= w;
        directOffset <= o;
        operandX <= x;
        nibbleSel <= s;
        @(posedge sys_clk);
        accessValid <= 1'b0;
        #1;
    endtask
    task automatic cmd(input page_cmd_t c, input logic [8:0] v,
        input logic m = 1'b0);
        @(posedge sys_clk);
        instrDone <= 1'b1;
        pageCmd <= c;
        pageValue <= v;
        compareMatch <= m;
        @(posedge sys_clk);
        instrDone <= 1'b0;
        pageCmd <= CMD_NONE;
        compareMatch <= 1'b0;
        #1;
    endtask
    // ==================================================
    // Scenarios
    task automatic t_groups();
        access_kind_t k[3] = '{ACC_FIRST_BACKUP, ACC_SECOND_BACKUP,
            ACC_STACK};
        logic [12:0] b[3] = '{13'h0080, 13'h00c0, 13'h0200};
        for (int i = 0; i < 3; i++)
            for (int x = 0; x < 16; x += 15)
                for (int s = 0; s < 4; s++) begin
                    acc(k[i], 1'b0, 7'h00, 4'(x), 2'(s));
                    `CHK("group", b[i] + 13'(4 * x + s), ramAddress)
                end
    endtask
    task automatic t_display();
        acc(ACC_DISPLAY_DIRECT, 1'b1, 7'h03);
        `CHK("addr", 13'h0106, ramAddress)
        `CHK("high", 1'b1, ramWriteHigh)
        `CHK("data", 8'h5a, {ramDataHigh, ramDataLow})
        acc(ACC_DISPLAY_DIRECT, 1'b0, 7'h03);
        `CHK("refuse", 2'b10, {accessRefused, ramWrite})
        acc(ACC_WORK_DIRECT, 1'b1, 7'h05);
        `CHK("work", 13'h0075, ramAddress)
    endtask
    task automatic t_locks();
        // Locks are set and cleared in straight-line order only.
        cmd(CMD_LOCK_DISPLAY, 9'h003);
        `CHK("inhibit", 1'b1, irqInhibit)
        acc(ACC_DISPLAY_DIRECT, 1'b1, 7'h1f);
        `CHK("addr", 13'h01fe, ramAddress)
        acc(ACC_DISPLAY_DIRECT, 1'b1, 7'h00);
        `CHK("addr", 13'h01c0, ramAddress)
        cmd(CMD_LOCK_WORK, 9'h1f3);
        acc(ACC_WORK_DIRECT, 1'b1, 7'h0a);
        `CHK("work", 13'h1f3a, ramAddress)
        cmd(CMD_CLEAR_LOCKS, 9'h004);
        `CHK("page", DISPLAY_INIT_PAGE, displayPage)
        `CHK("inhibit", 1'b1, irqInhibit)
        cmd(CMD_CLEAR_LOCKS, 9'h002);
        `CHK("wpage", 9'h007, workPage)
        `CHK("inhibit", 1'b0, irqInhibit)
    endtask
    task automatic t_oneshot();
        cmd(CMD_ONESHOT_DISPLAY, 9'h002);
        `CHK("inhibit", 1'b1, irqInhibit)
        acc(ACC_DISPLAY_DIRECT, 1'b1, 7'h01);
        `CHK("addr", 13'h0182, ramAddress)
        cmd(CMD_NONE, 9'h000);
        cmd(CMD_NONE, 9'h000);
        `CHK("inhibit", 1'b0, irqInhibit)
        acc(ACC_DISPLAY_DIRECT, 1'b1, 7'h01);
        `CHK("addr", 13'h0102, ramAddress)
        cmd(CMD_ONESHOT_WORK, 9'h00a);
        `CHK("inhibit", 1'b1, irqInhibit)
        acc(ACC_WORK_DIRECT, 1'b1, 7'h01);
        `CHK("work", 13'h00a1, ramAddress)
        cmd(CMD_NONE, 9'h000);
        cmd(CMD_NONE, 9'h000);
    endtask
    task automatic t_squash();
        cmd(CMD_NONE, 9'h000, 1'b1);
        `CHK("squash", 1'b1, squashNext)
        cmd(CMD_LOCK_DISPLAY, 9'h001);
        `CHK("lock", 3'b000, {displayPage, irqInhibit})
    endtask
    task automatic t_index();
        @(posedge sys_clk);
        indexAddress <= 13'h1abc;
        writeNibble <= 4'hf;
        acc(ACC_INDEX, 1'b1, 7'h00);
        `CHK("index", 13'h1abc, ramAddress)
        `CHK("ihigh", 1'b1, ramWriteHigh)
        acc(ACC_SECOND_BACKUP, 1'b1, 7'h00, 4'h2, 2'h3);
        `CHK("zaddr", 13'h00cb, ramAddress)
        `CHK("zbit", 4'h1, ramDataLow)
        cmd(CMD_LOCK_DATA, 9'h002);
        acc(ACC_DATA_DIRECT, 1'b1, 7'h05);
        `CHK("data", 13'h0105, ramAddress)
        `CHK("dwrite", 1'b1, ramWrite)
        cmd(CMD_CLEAR_LOCKS, 9'h001);
        `CHK("inhibit", 1'b0, irqInhibit)
        cmd(CMD_ONESHOT_DATA, 9'h003);
        acc(ACC_DATA_DIRECT, 1'b0, 7'h7f);
        `CHK("dshot", 13'h01ff, ramAddress)
        cmd(CMD_NONE, 9'h000);
        cmd(CMD_NONE, 9'h000);
    endtask
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        `CHK("wpage", 9'h007, workPage)
        `CHK("dpage", 2'h0, displayPage)
        t_groups();
        t_display();
        t_locks();
        t_oneshot();
        t_squash();
        t_index();
        summarize();
    end
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule
bind data_ram_page_mapper ram_page_monitor mon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .instrDone(instrDone),
    .accessValid(accessValid),
    .accessKind(accessKind),
    .accessWrite(accessWrite),
    .byteWide(byteWide),
    .directOffset(directOffset),
    .operandX(operandX),
    .nibbleSel(nibbleSel),
    .writeByte(writeByte),
    .pageCmd(pageCmd),
    .pageValue(pageValue),
    .compareMatch(compareMatch),
    .ramAddress(ramAddress),
    .ramWrite(ramWrite),
    .ramWriteHigh(ramWriteHigh),
    .ramDataHigh(ramDataHigh),
    .accessRefused(accessRefused),
    .squashNext(squashNext),
    .irqInhibit(irqInhibit),
    .displayPage(displayPage),
    .workPage(workPage)
);
`default_nettype wire
